// File: core/dpf_pkg.sv
// Shared constants for the dual PWM and square-wave pin generator
package dpf_pkg;

   // ==========================================================
   // Clocks and timing
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned TICK_HZ        = 1_000_000;
   localparam int unsigned TICK_DIV       = CLK_HZ / TICK_HZ;
   localparam int unsigned SQUARE_WAVE_OUTPUT_MAX_HZ    = 4_000_000;
   localparam int unsigned TIMER_WIDTH    = 32;
   localparam int unsigned NUM_PINS       = 2;
   localparam int unsigned SYNC_STAGES    = 2;
   localparam int unsigned HW_RESET_MIN_MS = 100;
   // Largest phase step allowed: 4 MHz out of a 32-bit accumulator at CLK_HZ
   localparam longint unsigned SQUARE_WAVE_OUTPUT_INC_MAX_L =
      (64'(SQUARE_WAVE_OUTPUT_MAX_HZ) * 64'h0000_0001_0000_0000) / 64'(CLK_HZ);
   localparam logic [31:0] SQUARE_WAVE_OUTPUT_INC_MAX = SQUARE_WAVE_OUTPUT_INC_MAX_L[31:0];

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_PERIOD = 8'h04;
   localparam logic [7:0] OFF_DUTY0  = 8'h08;
   localparam logic [7:0] OFF_DUTY1  = 8'h0c;
   localparam logic [7:0] OFF_SQUARE_WAVE_OUTPUT   = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;

   // ==========================================================
   // Control register fields
   localparam int unsigned CTRL_FUNC0_LSB = 0;
   localparam int unsigned CTRL_FUNC1_LSB = 2;
   localparam int unsigned CTRL_LEVEL_LSB = 4;
   localparam int unsigned FUNC_W         = 2;
   localparam int unsigned STAT_PIN_LSB   = 0;

   // Pin function codes
   typedef enum logic [1:0] {
      FUNC_GPIO = 2'h0,
      FUNC_PWM  = 2'h1,
      FUNC_SQUARE_WAVE_OUTPUT = 2'h2,
      FUNC_OFF  = 2'h3
   } dpf_func_t;

   // ==========================================================
   // Reset values
   localparam logic [1:0]  RST_FUNC   = 2'h0;
   localparam logic [1:0]  RST_LEVEL  = 2'h0;
   localparam logic [31:0] RST_PERIOD = 32'h0000_03e8;
   localparam logic [31:0] RST_DUTY   = 32'h0000_0000;
   localparam logic [31:0] RST_SQUARE_WAVE_OUTPUT   = 32'h0000_0000;

   // AHB transfer type bit that marks NONSEQ/SEQ
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;

endpackage

// File: core/dpf_pwm_chan.sv
// One PWM channel: 32-bit timer on the 1 MHz tick with shadowed settings
`timescale 1ns/1ns
module dpf_pwm_chan #(
   parameter int unsigned WIDTH = 32
) (
   input  wire logic             mclk,     // System clock
   input  wire logic             rst,      // Synchronous reset, high
   input  wire logic             ce,       // Clock enable
   input  wire logic             tick,     // 1 MHz time base pulse
   input  wire logic [WIDTH-1:0] period,   // Ticks per period
   input  wire logic [WIDTH-1:0] duty,     // Ticks high per period
   output logic                  pwmOut    // PWM waveform
);

   generate
      if (WIDTH < 2) begin : gBadWidth
         $error("dpf_pwm_chan: WIDTH must be at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] periodShadow;
   logic [WIDTH-1:0] dutyShadow;

   wire logic [WIDTH-1:0] countInc  = count + {{(WIDTH-1){1'b0}}, 1'b1};
   // A zero period means stopped; it is polled every tick
   wire logic             lastTick  = (periodShadow == '0) || (countInc == periodShadow);
   wire logic             nextHigh  = (period != '0) && (duty != '0);

   // ==========================================================
   // Timer and compare
   always_ff @(posedge mclk) begin
      if (rst) begin
         count        <= '0;
         periodShadow <= '0;
         dutyShadow   <= '0;
         pwmOut       <= 1'b0;
      end else if (ce && tick) begin
         if (lastTick) begin
            count        <= '0;
            periodShadow <= period;
            dutyShadow   <= duty;
            pwmOut       <= nextHigh;
         end else begin
            count  <= countInc;
            pwmOut <= (countInc < dutyShadow);
         end
      end
   end

endmodule // dpf_pwm_chan

// File: core/dpf_square_wave_output_nco.sv
// Square-wave source: phase accumulator whose top bit is the output
`timescale 1ns/1ns
module dpf_square_wave_output_nco #(
   parameter int unsigned WIDTH = 32
) (
   input  wire logic             mclk,     // System clock
   input  wire logic             rst,      // Synchronous reset, high
   input  wire logic             ce,       // Clock enable
   input  wire logic [WIDTH-1:0] step,     // Phase step per clock
   output logic                  sqOut     // Square wave, equal halves
);

   generate
      if (WIDTH < 2) begin : gBadWidth
         $error("dpf_square_wave_output_nco: WIDTH must be at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] phase;
   logic [WIDTH-1:0] stepShadow;

   wire logic [WIDTH:0] sum  = {1'b0, phase} + {1'b0, stepShadow};
   // Wrap marks the end of a high half, the end of one output period
   wire logic           wrap = sum[WIDTH] || (stepShadow == '0);

   always_ff @(posedge mclk) begin
      if (rst) begin
         phase      <= '0;
         stepShadow <= '0;
         sqOut      <= 1'b0;
      end else if (ce) begin
         phase <= sum[WIDTH-1:0];
         sqOut <= sum[WIDTH-1];
         if (wrap) begin
            stepShadow <= step;
         end
      end
   end

endmodule // dpf_square_wave_output_nco

// File: core/dpf_top.sv
// Dual pin PWM / square-wave generator with AHB-Lite register slave
`timescale 1ns/1ns
module dpf_top #(
   parameter int unsigned CLK_HZ  = dpf_pkg::CLK_HZ,
   parameter int unsigned TICK_HZ = dpf_pkg::TICK_HZ
) (
   input  wire logic        mclk,          // System clock, 50 MHz
   input  wire logic        rst,           // Synchronous reset, active high
   input  wire logic        ce,            // Clock enable, freezes all state when low
   input  wire logic        hwResetLow,    // Hardware reset pin, active low
   input  wire logic        hsel,          // AHB slave select
   input  wire logic [31:0] haddr,         // AHB address
   input  wire logic [1:0]  htrans,        // AHB transfer type
   input  wire logic        hwrite,        // AHB write
   input  wire logic [2:0]  hsize,         // AHB size, word only
   input  wire logic [31:0] hwdata,        // AHB write data
   input  wire logic        hready,        // AHB bus ready
   output logic      [31:0] hrdata,        // AHB read data
   output logic             hreadyout,     // AHB slave ready
   output logic             hresp,         // AHB response, always OKAY
   output logic      [1:0]  generalIoPin   // Pin levels
);

   localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
   localparam int unsigned TICK_W   = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

   generate
      if (TICK_HZ == 0 || CLK_HZ % TICK_HZ != 0 || TICK_DIV < 2) begin : gBadClk
         $error("dpf_top: CLK_HZ must be a multiple of TICK_HZ, at least twice");
      end
      if (CLK_HZ < 2 * dpf_pkg::SQUARE_WAVE_OUTPUT_MAX_HZ) begin : gBadFreq
         $error("dpf_top: CLK_HZ too low for the square-wave range");
      end
   endgenerate

   // ==========================================================
   // Hardware reset pin synchroniser
   logic hwRstMeta;
   logic hwRstSync;
   wire logic coreRst = rst || !hwRstSync;

   always_ff @(posedge mclk) begin
      if (rst) begin
         hwRstMeta <= 1'b0;
         hwRstSync <= 1'b0;
      end else if (ce) begin
         hwRstMeta <= hwResetLow;
         hwRstSync <= hwRstMeta;
      end
   end

   // ==========================================================
   // Address decode helper
   function automatic logic isReg(input logic [7:0] addr, input logic [7:0] off);
      isReg = (addr[7:2] == off[7:2]);
   endfunction

   // ==========================================================
   // AHB-Lite address and data phase tracking
   wire logic addrPhase = hsel && htrans[dpf_pkg::HTRANS_ACTIVE_BIT] && hready;
   wire logic rdStart   = addrPhase && !hwrite;
   wire logic inWindow  = (haddr[31:8] == 24'h000000);

   logic       wrPend;
   logic [7:0] wrAddr;

   always_ff @(posedge mclk) begin
      if (coreRst) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
      end else if (ce) begin
         wrPend <= addrPhase && hwrite && inWindow;
         if (addrPhase) begin
            wrAddr <= haddr[7:0];
         end
      end
   end

   // ==========================================================
   // Register file
   logic [1:0]  pinFunc [dpf_pkg::NUM_PINS];
   logic [1:0]  gpioLevel;
   logic [31:0] periodReg;
   logic [31:0] dutyReg [dpf_pkg::NUM_PINS];
   logic [31:0] freqReg;

   wire logic wrCtrl   = wrPend && isReg(wrAddr, dpf_pkg::OFF_CTRL);
   wire logic wrPeriod = wrPend && isReg(wrAddr, dpf_pkg::OFF_PERIOD);
   wire logic wrDuty0  = wrPend && isReg(wrAddr, dpf_pkg::OFF_DUTY0);
   wire logic wrDuty1  = wrPend && isReg(wrAddr, dpf_pkg::OFF_DUTY1);
   wire logic wrFreq   = wrPend && isReg(wrAddr, dpf_pkg::OFF_SQUARE_WAVE_OUTPUT);

   // Steps above the 4 MHz limit are clamped when stored
   wire logic [31:0] freqClamped =
      (hwdata > dpf_pkg::SQUARE_WAVE_OUTPUT_INC_MAX) ? dpf_pkg::SQUARE_WAVE_OUTPUT_INC_MAX : hwdata;

   // Values after this cycle's write; reads see them so a read right
   // behind a write returns the new contents
   wire logic [1:0]  next_func0  = wrCtrl ?
      hwdata[dpf_pkg::CTRL_FUNC0_LSB +: dpf_pkg::FUNC_W] : pinFunc[0];
   wire logic [1:0]  next_func1  = wrCtrl ?
      hwdata[dpf_pkg::CTRL_FUNC1_LSB +: dpf_pkg::FUNC_W] : pinFunc[1];
   wire logic [1:0]  next_level  = wrCtrl ?
      hwdata[dpf_pkg::CTRL_LEVEL_LSB +: 2] : gpioLevel;
   wire logic [31:0] next_period = wrPeriod ? hwdata : periodReg;
   wire logic [31:0] next_duty0  = wrDuty0 ? hwdata : dutyReg[0];
   wire logic [31:0] next_duty1  = wrDuty1 ? hwdata : dutyReg[1];
   wire logic [31:0] next_square_wave_output   = wrFreq ? freqClamped : freqReg;

   always_ff @(posedge mclk) begin
      if (coreRst) begin
         pinFunc[0] <= dpf_pkg::RST_FUNC;
         pinFunc[1] <= dpf_pkg::RST_FUNC;
         gpioLevel  <= dpf_pkg::RST_LEVEL;
         periodReg  <= dpf_pkg::RST_PERIOD;
         dutyReg[0] <= dpf_pkg::RST_DUTY;
         dutyReg[1] <= dpf_pkg::RST_DUTY;
         freqReg    <= dpf_pkg::RST_SQUARE_WAVE_OUTPUT;
      end else if (ce) begin
         pinFunc[0] <= next_func0;
         pinFunc[1] <= next_func1;
         gpioLevel  <= next_level;
         periodReg  <= next_period;
         dutyReg[0] <= next_duty0;
         dutyReg[1] <= next_duty1;
         freqReg    <= next_square_wave_output;
      end
   end

   // ==========================================================
   // Read data selection
   wire logic [7:0]  rdAddr  = haddr[7:0];
   wire logic [31:0] ctrlRd  = {26'h0000000, next_level, next_func1, next_func0};
   wire logic [31:0] statRd  = {30'h00000000, generalIoPin};
   wire logic [31:0] rdValue =
      !inWindow                                  ? 32'h0000_0000 :
      isReg(rdAddr, dpf_pkg::OFF_CTRL)   ? ctrlRd      :
      isReg(rdAddr, dpf_pkg::OFF_PERIOD) ? next_period :
      isReg(rdAddr, dpf_pkg::OFF_DUTY0)  ? next_duty0  :
      isReg(rdAddr, dpf_pkg::OFF_DUTY1)  ? next_duty1  :
      isReg(rdAddr, dpf_pkg::OFF_SQUARE_WAVE_OUTPUT)   ? next_square_wave_output   :
      isReg(rdAddr, dpf_pkg::OFF_STATUS) ? statRd      :
      32'h0000_0000;

   // Zero wait states: every transfer completes in its first data cycle
   always_ff @(posedge mclk) begin
      if (coreRst) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (rdStart) begin
            hrdata <= rdValue;
         end
      end
   end

   // ==========================================================
   // 1 MHz time base
   logic [TICK_W-1:0] tickCount;
   logic              tick;

   always_ff @(posedge mclk) begin
      if (coreRst) begin
         tickCount <= '0;
         tick      <= 1'b0;
      end else if (ce) begin
         tick <= (tickCount == TICK_LAST);
         if (tickCount == TICK_LAST) begin
            tickCount <= '0;
         end else begin
            tickCount <= tickCount + TICK_W'(1);
         end
      end
   end

   // ==========================================================
   // Waveform sources
   logic [dpf_pkg::NUM_PINS-1:0] pwmWave;
   logic                         sqWave;

   generate
      for (genvar i = 0; i < dpf_pkg::NUM_PINS; i++) begin : gChan
         dpf_pwm_chan #(
            .WIDTH (dpf_pkg::TIMER_WIDTH)
         ) uChan (
            .mclk   (mclk),
            .rst    (coreRst),
            .ce     (ce),
            .tick   (tick),
            .period (periodReg),
            .duty   (dutyReg[i]),
            .pwmOut (pwmWave[i])
         );
      end
   endgenerate

   dpf_square_wave_output_nco #(
      .WIDTH (32)
   ) uNco (
      .mclk  (mclk),
      .rst   (coreRst),
      .ce    (ce),
      .step  (freqReg),
      .sqOut (sqWave)
   );

   // ==========================================================
   // Pin function selection
   logic [1:0] pinSel;

   generate
      for (genvar i = 0; i < dpf_pkg::NUM_PINS; i++) begin : gPin
         assign pinSel[i] =
            (pinFunc[i] == dpf_pkg::FUNC_PWM)  ? pwmWave[i]   :
            (pinFunc[i] == dpf_pkg::FUNC_SQUARE_WAVE_OUTPUT) ? sqWave       :
            (pinFunc[i] == dpf_pkg::FUNC_GPIO) ? gpioLevel[i] :
            1'b0;
      end
   endgenerate

   // One process owns the whole pin vector
   always_ff @(posedge mclk) begin
      if (coreRst) begin
         generalIoPin <= 2'h0;
      end else if (ce) begin
         generalIoPin <= pinSel;
      end
   end

endmodule // dpf_top

// File: bench/dpf_top_chk.sv
// Concurrent checks on the ports of the dual PWM and square-wave generator
`timescale 1ns/1ns
module dpf_top_chk (
   input wire logic        mclk,         // System clock
   input wire logic        rst,          // Synchronous reset, high
   input wire logic        ce,           // Clock enable
   input wire logic        hwResetLow,   // Hardware reset pin, low
   input wire logic        hsel,         // AHB select
   input wire logic [31:0] haddr,        // AHB address
   input wire logic [1:0]  htrans,       // AHB transfer type
   input wire logic        hwrite,       // AHB write
   input wire logic [31:0] hwdata,       // AHB write data
   input wire logic        hready,       // AHB bus ready
   input wire logic [31:0] hrdata,       // AHB read data
   input wire logic        hreadyout,    // AHB slave ready
   input wire logic        hresp,        // AHB response
   input wire logic [1:0]  generalIoPin  // Pin levels
);
   // ==========================================
   // Shadow of the control word
   logic [3:0]  hwLow;
   logic        hwWin;
   logic        take;
   logic        wrCtrl;
   logic [31:0] ctrlSh;
   assign take  = hsel && htrans[1] && hready && ce;
   // Covers the pin reset plus its synchroniser delay
   assign hwWin = !hwResetLow || (|hwLow);
   always_ff @(posedge mclk) begin
      hwLow <= {hwLow[2:0], !hwResetLow};
   end
   always_ff @(posedge mclk) begin
      if (rst || hwWin) begin
         wrCtrl <= 1'b0;
         ctrlSh <= 32'h0000_0000;
      end else if (ce) begin
         wrCtrl <= take && hwrite && haddr == 32'h0000_0000;
         if (wrCtrl) begin
            ctrlSh <= hwdata;
         end
      end
   end
   // ==========================================
   // Assertions
   default clocking @(posedge mclk); endclocking
   default disable iff (rst || hwWin);
   a_resp_okay: assert property (!hresp)
      else $error("response not OKAY");
   a_ready_high: assert property (hreadyout)
      else $error("slave ready low");
   a_reset_clear: assert property ($fell(rst) |-> generalIoPin == 2'h0 && hrdata == 32'h0)
      else $error("outputs not cleared by reset");
   a_status_read: assert property (
      take && !hwrite && haddr == 32'h0000_0014 |=> hrdata == {30'h0, $past(generalIoPin)})
      else $error("status read differs from pins");
   a_unmapped_zero: assert property (
      take && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");
   a_level_latency: assert property (
      wrCtrl && hwdata[3:0] == 4'h0 |=> ##1 generalIoPin == $past(hwdata[5:4], 2))
      else $error("level not on pins two edges after write");
   a_gpio_follow: assert property (
      $past(ctrlSh[1:0]) == 2'h0 |-> generalIoPin[0] == $past(ctrlSh[4]))
      else $error("pin 0 not following its level");
   a_off_low: assert property ($past(ctrlSh[3:2]) == 2'h3 |-> !generalIoPin[1])
      else $error("pin 1 not low when off");
   c_write: cover property (take && hwrite);
   c_pwm_rise: cover property ($past(ctrlSh[1:0]) == 2'h1 && $rose(generalIoPin[0]));
   c_sq_rise: cover property ($past(ctrlSh[3:2]) == 2'h2 && $rose(generalIoPin[1]));
endmodule // dpf_top_chk

bind dpf_top dpf_top_chk chk_u (
   .mclk(mclk), .rst(rst), .ce(ce), .hwResetLow(hwResetLow), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .generalIoPin(generalIoPin)
);

// File: bench/dual_pwm_square_wave_output_output_tb.sv
// Self-checking bench for the dual PWM and square-wave generator
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
   $display("mismatch at %0t got %h expected %h", $time, a, b); end end
module dual_pwm_square_wave_output_output_tb;
   // Faster time base keeps the reset period of 1000 ticks short
   localparam int TD = 10;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        hwResetLow = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [1:0]  generalIoPin;
   logic [31:0] rd;
   logic        ce = 1'b1;
   logic [1:0]  pinHold;
   int          n_fail = 0;
   int          compares = 0;
   int          hi0, hi1, rise0, len, p, d;
   int          cfg [3][3] = '{'{4, 1, 3}, '{4, 0, 4}, '{2, 1, 5}};
   logic [31:0] rAdr [8] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h14, 32'h100, 32'h104, 32'h18};
   logic [31:0] rVal [8] = '{32'h0, 32'h3e8, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

   dpf_top #(.CLK_HZ(50_000_000), .TICK_HZ(50_000_000 / TD)) dut_u (
      .mclk(mclk), .rst(rst), .ce(ce), .hwResetLow(hwResetLow), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .generalIoPin(generalIoPin));

   initial begin
      forever #10 mclk = ~mclk;
   end

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic waitRdy();
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_fail++;
         end_sim();
      end
   endtask

   // ==========================================
   // One single AHB transfer, address then data phase
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dt);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= dt;
      waitRdy();
      rd = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] dt);
      bus(1'b1, a, dt);
   endtask

   task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask

   // High samples of both pins and rises of pin 0 over n clocks
   task automatic measure(input int n);
      logic last;
      hi0 = 0;
      hi1 = 0;
      rise0 = 0;
      @(negedge mclk);
      last = generalIoPin[0];
      repeat (n) begin
         @(negedge mclk);
         hi0 += int'(generalIoPin[0] === 1'b1);
         hi1 += int'(generalIoPin[1] === 1'b1);
         rise0 += int'(generalIoPin[0] === 1'b1 && last === 1'b0);
         last = generalIoPin[0];
      end
   endtask

   task automatic waitRise();
      int k;
      k = 0;
      @(negedge mclk);
      while (generalIoPin[0] !== 1'b0 && k < 500) begin @(negedge mclk); k++; end
      while (generalIoPin[0] !== 1'b1 && k < 500) begin @(negedge mclk); k++; end
      if (k >= 500) begin
         n_fail++;
         end_sim();
      end
   endtask

   task automatic runLen();
      len = 0;
      while (generalIoPin[0] === 1'b1 && len < 1000) begin
         len++;
         @(negedge mclk);
      end
   endtask

   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      // ==========================================
      // Reset values, unmapped write ignored
      wr(32'h104, 32'h5);
      for (int i = 0; i < 8; i++) rdChk(rAdr[i], rVal[i]);
      wr(32'h04, 32'hffff_ffff);
      rdChk(32'h04, 32'hffff_ffff);
      wr(32'h10, 32'hffff_ffff);
      rdChk(32'h10, dpf_pkg::SQUARE_WAVE_OUTPUT_INC_MAX);
      // ==========================================
      // Level mode, then function off
      wr(32'h04, 32'h4);
      for (int v = 0; v < 4; v++) begin
         wr(32'h00, 32'(v) << 4);
         repeat (3) @(posedge mclk);
         `CHK(generalIoPin, 2'(v))
         rdChk(32'h14, 32'(v));
      end
      wr(32'h00, 32'h3f);
      repeat (3) @(posedge mclk);
      `CHK(generalIoPin, 2'h0)
      // ==========================================
      // PWM on both pins: shared period, own duties
      wr(32'h00, 32'h5);
      for (int i = 0; i < 3; i++) begin
         p = cfg[i][0];
         d = cfg[i][1];
         wr(32'h04, 32'(p));
         wr(32'h08, 32'(d));
         wr(32'h0c, 32'(cfg[i][2]));
         repeat (i == 0 ? 10500 : 200) @(posedge mclk);
         measure(2000);
         `CHK(hi0, 2000 * d / p)
         `CHK(hi1, 2000 * (cfg[i][2] < p ? cfg[i][2] : p) / p)
         `CHK(rise0, (d > 0 && d < p) ? 2000 / (p * TD) : 0)
      end
      // Duty change in mid-pulse waits for the period end
      wr(32'h04, 32'h4);
      wr(32'h08, 32'h3);
      repeat (200) @(posedge mclk);
      waitRise();
      fork
         wr(32'h08, 32'h1);
         runLen();
      join
      `CHK(len, 3 * TD)
      waitRise();
      runLen();
      `CHK(len, TD)
      // Zero period stops both pins low
      wr(32'h04, 32'h0);
      repeat (200) @(posedge mclk);
      measure(400);
      `CHK(hi0 + hi1, 0)
      // ==========================================
      // Square wave at 1/32 of the clock, then 0 Hz
      wr(32'h10, 32'h0800_0000);
      wr(32'h00, 32'ha);
      repeat (100) @(posedge mclk);
      measure(3200);
      `CHK(hi0, 1600)
      `CHK(hi1, 1600)
      `CHK(rise0, int'((64'd3200 * 64'h0800_0000) >> 32))
      // Clock enable low freezes the running square wave
      @(posedge mclk);
      ce <= 1'b0;
      repeat (2) @(posedge mclk);
      pinHold = generalIoPin;
      repeat (40) @(posedge mclk);
      `CHK(generalIoPin, pinHold)
      ce <= 1'b1;
      wr(32'h10, 32'h0);
      repeat (100) @(posedge mclk);
      measure(400);
      `CHK(hi0 + hi1, 0)
      // ==========================================
      // Hardware reset pin: a short four-cycle pulse, the core needs only one sampled low cycle
      @(posedge mclk);
      hwResetLow <= 1'b0;
      repeat (4) @(posedge mclk);
      hwResetLow <= 1'b1;
      repeat (4) @(posedge mclk);
      rdChk(32'h04, 32'h3e8);
      `CHK(generalIoPin, 2'h0)
      end_sim();
   end
endmodule // dual_pwm_square_wave_output_output_tb
